// file: src/wcm_pkg.sv
// Constants, display codes and the operating summary of the weld current monitor.
// Overview of operation
// - With the weld current shown after a weld, the ones button selects phase shift, the tens button selects the last kiloamps and any other button blanks the display.
// - A sequence that ended with compensation saturated because the machine range is too low shows the tap-raise message.
// - A sequence that ended with compensation saturated because the machine range is too high shows the tap-lower message.
// - While a tap message is shown the same ones, tens and clear buttons work as for the current readout.
// - Process output 12 in constant-current mode shows the maintained current at sequence end, with LO or HI flashing on a window violation.
// - With a window monitored, the maintained current is shown when held, otherwise LO or HI is shown, flashing except under process output 14.
// - Process output 13 gives the same readout and pulses the alarm valve for 30 line cycles on a window violation.
// - Process output 14 on a window violation shows LO or HI steadily, aborts a repeat and locks out initiations.
// - Any front-panel button clears the latched HI/LO error and the lockout, after which initiations are taken again.
// - A zero HI or LO limit makes the window the programmed current plus and minus 10 percent.
// - Selector value 00 disables compensation and the weld fires at the programmed percent.
// - In constant-current mode the firing percent is steered within 20 to 99 percent to hold the current.
// - Selector values 10, 20 and 30 choose regulation for the fitted sensor.
// - Other process outputs show the current at sequence end only if percent current was selected before initiation.
// - A range of 00.99 selects percent mode and any other value selects kiloamp mode.
package wcm_pkg;
	localparam logic [7:0]  PO_READOUT      = 8'h0C;
	localparam logic [7:0]  PO_ALARM        = 8'h0D;
	localparam logic [7:0]  PO_STOP         = 8'h0E;
	localparam logic [7:0]  REG_OFF         = 8'h00;
	localparam logic [7:0]  REG_SENSOR_A    = 8'h0A;
	localparam logic [7:0]  REG_SENSOR_B    = 8'h14;
	localparam logic [7:0]  REG_SENSOR_C    = 8'h1E;
	localparam logic [15:0] RANGE_PERCENT   = 16'h0063;
	localparam logic [7:0]  FIRE_MIN_PCT    = 8'h14;
	localparam logic [7:0]  FIRE_MAX_PCT    = 8'h63;
	localparam logic [15:0] WINDOW_DIVISOR  = 16'h000A;
	localparam logic [5:0]  VALVE_LINE_CYCLES = 6'h1E;

	typedef enum logic [2:0] {
		DSP_BLANK,
		DSP_CURRENT,
		DSP_PHASE,
		DSP_TAP_UP,
		DSP_TAP_DN,
		DSP_LO,
		DSP_HI
	} wcm_display_type;
endpackage

// file: src/wcm_pin_sync.sv
// Three-stage pin synchroniser with agreement check and rising-edge pulse.
`timescale 1ns/10ps
module wcm_pin_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Pin side and clean side.
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change is taken only once the second and third stages agree.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			level <= '0;
			rise  <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
				rise[i] <= (stage2[i] == stage3[i]) && stage3[i] && !level[i];
			end
		end
	end
endmodule

// file: src/wcm_monitor.sv
// Weld current monitor: end-of-sequence readout, window check, alarm valve and lockout.
`timescale 1ns/10ps
module wcm_monitor (
	// Clock and reset.
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	// Front panel and initiation pins.
	input  wire logic                     btn_data_ones,
	input  wire logic                     btn_data_tens,
	input  wire logic                     btn_other,
	input  wire logic                     weld_initiate_switch,
	input  wire logic                     percent_selected,
	// Configuration.
	input  wire logic [7:0]               process_output_sel,
	input  wire logic [7:0]               regulation_sel,
	input  wire logic [15:0]              current_range,
	input  wire logic [15:0]              programmed_current,
	input  wire logic [15:0]              hi_limit,
	input  wire logic [15:0]              lo_limit,
	// Weld machine and sensor.
	input  wire logic                     line_cycle,
	input  wire logic                     seq_end,
	input  wire logic                     range_too_low,
	input  wire logic                     range_too_high,
	input  wire logic [15:0]              measured_current,
	input  wire logic [7:0]               phase_shift,
	// Results.
	output wcm_pkg::wcm_display_type      display_code,
	output logic      [15:0]              display_value,
	output logic                          display_flash,
	output logic                          alarm_valve_output,
	output logic                          weld_start,
	output logic                          repeat_abort,
	output logic                          initiate_locked,
	output logic                          cc_enable,
	output logic                          ka_mode,
	output logic      [7:0]               firing_percent
);
	import wcm_pkg::*;

	logic [3:0]  pin_level;
	logic [3:0]  pin_rise;
	logic        press_ones;
	logic        press_tens;
	logic        press_any;
	logic        init_edge;
	logic        pct_at_init;
	logic [15:0] last_current;
	logic [5:0]  valve_count;
	logic [15:0] win_hi;
	logic [15:0] win_lo;
	logic        cc_readout;
	logic        show_result;
	logic        viol_lo;
	logic        viol_hi;
	logic        readout_state;

	function automatic logic is_selector(input logic [7:0] sel);
		is_selector = (sel == REG_SENSOR_A) || (sel == REG_SENSOR_B) || (sel == REG_SENSOR_C);
	endfunction

	wcm_pin_sync #(.WIDTH(4)) u_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pin     ({weld_initiate_switch, btn_other, btn_data_tens, btn_data_ones}),
		.level   (pin_level),
		.rise    (pin_rise)
	);

	assign press_ones = pin_rise[0];
	assign press_tens = pin_rise[1];
	assign press_any  = |pin_rise[2:0];
	assign init_edge  = pin_rise[3];

	// A zero limit falls back to a window of ten percent around the target.
	always_comb begin
		if ((hi_limit == 16'h0000) || (lo_limit == 16'h0000)) begin
			win_hi = programmed_current + programmed_current / WINDOW_DIVISOR;
			win_lo = programmed_current - programmed_current / WINDOW_DIVISOR;
		end else begin
			win_hi = hi_limit;
			win_lo = lo_limit;
		end
	end

	assign cc_readout = cc_enable && ((process_output_sel == PO_READOUT) ||
		(process_output_sel == PO_ALARM) || (process_output_sel == PO_STOP));
	assign show_result = cc_readout || pct_at_init;
	assign viol_lo = cc_readout && (measured_current < win_lo);
	assign viol_hi = cc_readout && (measured_current > win_hi);
	assign readout_state = (display_code == DSP_CURRENT) || (display_code == DSP_PHASE) ||
		(display_code == DSP_TAP_UP) || (display_code == DSP_TAP_DN);

	// Regulation mode and range decoding.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cc_enable <= 1'b0;
			ka_mode   <= 1'b0;
		end else begin
			cc_enable <= is_selector(regulation_sel);
			ka_mode   <= (current_range != RANGE_PERCENT);
		end
	end

	// Firing percent: fixed when compensation is off, stepped and clamped otherwise.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			firing_percent <= FIRE_MIN_PCT;
		end else if (!cc_enable) begin
			firing_percent <= programmed_current[7:0];
		end else if (firing_percent < FIRE_MIN_PCT) begin
			firing_percent <= FIRE_MIN_PCT;
		end else if (firing_percent > FIRE_MAX_PCT) begin
			firing_percent <= FIRE_MAX_PCT;
		end else if (line_cycle) begin
			if ((measured_current < programmed_current) && (firing_percent < FIRE_MAX_PCT)) begin
				firing_percent <= firing_percent + 8'h01;
			end else if ((measured_current > programmed_current) &&
				(firing_percent > FIRE_MIN_PCT)) begin
				firing_percent <= firing_percent - 8'h01;
			end
		end
	end

	// Initiation is taken on the switch edge unless locked out or a button rises in the same cycle.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			weld_start  <= 1'b0;
			pct_at_init <= 1'b0;
		end else begin
			weld_start <= init_edge && !initiate_locked && !press_any;
			if (init_edge && !initiate_locked) begin
				pct_at_init <= percent_selected;
			end
		end
	end

	// Lockout and repeat abort under the stop option. A violation wins over a press.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			initiate_locked <= 1'b0;
			repeat_abort    <= 1'b0;
		end else begin
			repeat_abort <= 1'b0;
			if (seq_end && show_result && (viol_lo || viol_hi) &&
				(process_output_sel == PO_STOP)) begin
				initiate_locked <= 1'b1;
				repeat_abort    <= 1'b1;
			end else if (press_any) begin
				initiate_locked <= 1'b0;
			end
		end
	end

	// Alarm valve held for a fixed number of line cycles.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			valve_count        <= 6'h00;
			alarm_valve_output <= 1'b0;
		end else begin
			if (seq_end && show_result && (viol_lo || viol_hi) &&
				(process_output_sel == PO_ALARM)) begin
				valve_count        <= VALVE_LINE_CYCLES;
				alarm_valve_output <= 1'b1;
			end else if (line_cycle && (valve_count != 6'h00)) begin
				valve_count        <= valve_count - 6'h01;
				alarm_valve_output <= (valve_count != 6'h01);
			end
		end
	end

	// Display selection at sequence end and by the buttons.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			display_code  <= DSP_BLANK;
			display_value <= 16'h0000;
			display_flash <= 1'b0;
			last_current  <= 16'h0000;
		end else if (seq_end) begin
			last_current <= measured_current;
			if (show_result) begin
				display_value <= measured_current;
				display_flash <= (viol_lo || viol_hi) && (process_output_sel != PO_STOP);
				if (viol_lo) begin
					display_code <= DSP_LO;
				end else if (viol_hi) begin
					display_code <= DSP_HI;
				end else if (range_too_low) begin
					display_code <= DSP_TAP_UP;
				end else if (range_too_high) begin
					display_code <= DSP_TAP_DN;
				end else begin
					display_code <= DSP_CURRENT;
				end
			end
		end else if (readout_state && press_ones) begin
			display_code  <= DSP_PHASE;
			display_value <= {8'h00, phase_shift};
		end else if (readout_state && press_tens) begin
			display_code  <= DSP_CURRENT;
			display_value <= last_current;
		end else if (pin_rise[2] || ((press_ones || press_tens) && !readout_state &&
			(display_code != DSP_BLANK))) begin
			display_code  <= DSP_BLANK;
			display_value <= 16'h0000;
			display_flash <= 1'b0;
		end
	end

	// Checks.
	AST_PHASE_SELECT: assert property (@(posedge sys_clk) disable iff (reset)
		(!seq_end && readout_state && press_ones) |=> (display_code == DSP_PHASE) &&
		(display_value == {8'h00, $past(phase_shift)}))
		else $error("Ones button did not select phase shift.");
	AST_TAP_UP: assert property (@(posedge sys_clk) disable iff (reset)
		(seq_end && show_result && !viol_lo && !viol_hi && range_too_low)
		|=> display_code == DSP_TAP_UP)
		else $error("Tap-raise message missing.");
	AST_TAP_DN: assert property (@(posedge sys_clk) disable iff (reset)
		(seq_end && show_result && !viol_lo && !viol_hi && !range_too_low && range_too_high)
		|=> display_code == DSP_TAP_DN)
		else $error("Tap-lower message missing.");
	AST_READOUT: assert property (@(posedge sys_clk) disable iff (reset)
		(seq_end && cc_readout) |=> (display_code != DSP_BLANK) &&
		(display_value == $past(measured_current)))
		else $error("No readout at sequence end.");
	AST_VALVE_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
		(seq_end && cc_readout && (viol_lo || viol_hi) && (process_output_sel == PO_ALARM))
		|=> alarm_valve_output && (valve_count == VALVE_LINE_CYCLES))
		else $error("Alarm valve not started for 30 line cycles.");
	AST_VALVE_END: assert property (@(posedge sys_clk) disable iff (reset)
		(line_cycle && (valve_count == 6'h01) && !seq_end) |=> !alarm_valve_output)
		else $error("Alarm valve outlasted its count.");
	AST_LOCKOUT: assert property (@(posedge sys_clk) disable iff (reset)
		initiate_locked && !press_any |=> !weld_start)
		else $error("Initiation taken while locked out.");
	AST_UNLOCK: assert property (@(posedge sys_clk) disable iff (reset)
		(initiate_locked && press_any && !seq_end) |=> !initiate_locked)
		else $error("Button press did not clear the lockout.");
	AST_FIRE_RANGE: assert property (@(posedge sys_clk) disable iff (reset)
		(cc_enable && $past(cc_enable) && $past(cc_enable, 2) &&
		(firing_percent >= FIRE_MIN_PCT) && (firing_percent <= FIRE_MAX_PCT))
		|=> (firing_percent >= FIRE_MIN_PCT) && (firing_percent <= FIRE_MAX_PCT))
		else $error("Firing percent left its range.");
	// The edge that releases reset still loads the reset value, so it starts no check.
	AST_BYPASS: assert property (@(posedge sys_clk) disable iff (reset)
		!reset && !cc_enable |=> firing_percent == $past(programmed_current[7:0]))
		else $error("Fixed percent not applied with compensation off.");
	AST_KA_MODE: assert property (@(posedge sys_clk) disable iff (reset)
		##1 ka_mode == ($past(current_range) != RANGE_PERCENT))
		else $error("Range decode wrong.");

	COV_LO_FLASH: cover property (@(posedge sys_clk) disable iff (reset)
		seq_end && viol_lo ##1 display_flash);
	COV_STOP_LOCK: cover property (@(posedge sys_clk) disable iff (reset)
		$rose(initiate_locked) ##[1:50] !initiate_locked);
	COV_VALVE: cover property (@(posedge sys_clk) disable iff (reset)
		$rose(alarm_valve_output) ##[1:1000] $fell(alarm_valve_output));
	COV_PHASE: cover property (@(posedge sys_clk) disable iff (reset)
		display_code == DSP_TAP_UP ##1 display_code == DSP_PHASE);
endmodule

// file: test/wcm_operator.sv
// Operator and weld machine model: panel buttons, initiation switch, line and sequence strobes.
`timescale 1ns/10ps
module wcm_operator (
	// Clock and design answer.
	input  wire logic sys_clk,
	input  wire logic weld_start,
	// Panel and initiation pins.
	output logic      btn_data_ones,
	output logic      btn_data_tens,
	output logic      btn_other,
	output logic      weld_initiate_switch,
	// Machine strobes.
	output logic      line_cycle,
	output logic      seq_end
);
	logic [2:0] line_count = 3'h0;

	initial begin
		btn_data_ones = 1'b0;
		btn_data_tens = 1'b0;
		btn_other = 1'b0;
		weld_initiate_switch = 1'b0;
		seq_end = 1'b0;
	end

	// A line cycle every eight clocks keeps the valve timing short.
	always @(posedge sys_clk) begin
		line_count <= line_count + 3'h1;
		line_cycle <= (line_count == 3'h7);
	end

	// Buttons are held long enough for the synchroniser stages to agree.
	task automatic press(input int which);
		@(posedge sys_clk);
		case (which)
			0: btn_data_ones <= 1'b1;
			1: btn_data_tens <= 1'b1;
			default: btn_other <= 1'b1;
		endcase
		repeat (4) @(posedge sys_clk);
		btn_data_ones <= 1'b0;
		btn_data_tens <= 1'b0;
		btn_other <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic initiate(output logic started);
		started = 1'b0;
		@(posedge sys_clk);
		weld_initiate_switch <= 1'b1;
		repeat (8) begin
			@(posedge sys_clk);
			#1 started = started | weld_start;
		end
		@(posedge sys_clk);
		weld_initiate_switch <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic end_seq;
		@(posedge sys_clk);
		seq_end <= 1'b1;
		@(posedge sys_clk);
		seq_end <= 1'b0;
	endtask
endmodule

// file: test/tb.sv
// Testbench for the weld current monitor: readout, buttons, window, valve, lockout, firing.
`timescale 1ns/10ps
module tb;
	import wcm_pkg::*;
	logic sys_clk, reset, percent_selected, range_too_low, range_too_high;
	logic [7:0] process_output_sel, regulation_sel, phase_shift, firing_percent;
	logic [15:0] current_range, programmed_current, hi_limit, lo_limit, measured_current;
	logic [15:0] display_value;
	wcm_display_type display_code;
	logic display_flash, alarm_valve_output, weld_start, repeat_abort, initiate_locked;
	logic cc_enable, ka_mode, btn_data_ones, btn_data_tens, btn_other, weld_initiate_switch;
	logic line_cycle, seq_end, abort_seen, started;
	int n_fail = 0;
	int tests_run = 0;
	int n;
	int m;
	int valve_lines = 0;
	logic [7:0] regs [5] = '{8'h00, 8'h0A, 8'h14, 8'h1E, 8'h05};
	logic cc_exp [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

	wcm_monitor uut (.sys_clk(sys_clk), .reset(reset), .btn_data_ones(btn_data_ones),
		.btn_data_tens(btn_data_tens), .btn_other(btn_other),
		.weld_initiate_switch(weld_initiate_switch), .percent_selected(percent_selected),
		.process_output_sel(process_output_sel), .regulation_sel(regulation_sel),
		.current_range(current_range), .programmed_current(programmed_current),
		.hi_limit(hi_limit), .lo_limit(lo_limit), .line_cycle(line_cycle), .seq_end(seq_end),
		.range_too_low(range_too_low), .range_too_high(range_too_high),
		.measured_current(measured_current), .phase_shift(phase_shift),
		.display_code(display_code), .display_value(display_value),
		.display_flash(display_flash), .alarm_valve_output(alarm_valve_output),
		.weld_start(weld_start), .repeat_abort(repeat_abort),
		.initiate_locked(initiate_locked), .cc_enable(cc_enable), .ka_mode(ka_mode),
		.firing_percent(firing_percent));

	wcm_operator op (.sys_clk(sys_clk), .weld_start(weld_start), .btn_data_ones(btn_data_ones),
		.btn_data_tens(btn_data_tens), .btn_other(btn_other),
		.weld_initiate_switch(weld_initiate_switch), .line_cycle(line_cycle), .seq_end(seq_end));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Counts the line cycles that the design sees while the valve is on.
	always @(posedge sys_clk) begin
		if (alarm_valve_output === 1'b1 && line_cycle === 1'b1) valve_lines <= valve_lines + 1;
	end

	task automatic print_verdict;
		if (n_fail == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic disp(input wcm_display_type code, input logic flash);
		chk({13'h0000, display_code}, {13'h0000, code});
		chk({15'h0000, display_flash}, {15'h0000, flash});
	endtask

	// One initiation and sequence end; the abort pulse is caught over the answer cycles.
	task automatic weld(input logic [15:0] meas, input logic up, input logic dn);
		@(posedge sys_clk);
		measured_current <= meas;
		range_too_low <= up;
		range_too_high <= dn;
		op.initiate(started);
		chk({15'h0000, started}, 16'h0001);
		op.end_seq();
		#1 abort_seen = repeat_abort;
		repeat (2) begin
			@(posedge sys_clk);
			#1 abort_seen = abort_seen | repeat_abort;
		end
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		percent_selected = 1'b0;
		process_output_sel = PO_READOUT;
		regulation_sel = REG_OFF;
		current_range = RANGE_PERCENT;
		programmed_current = 16'h0064;
		hi_limit = 16'h00C8;
		lo_limit = 16'h000A;
		range_too_low = 1'b0;
		range_too_high = 1'b0;
		measured_current = 16'h0064;
		phase_shift = 8'h37;
		repeat (11) @(posedge sys_clk);
		#1 chk({8'h00, firing_percent}, {8'h00, FIRE_MIN_PCT});
		disp(DSP_BLANK, 1'b0);
		@(posedge sys_clk);
		reset <= 1'b0;
		foreach (regs[i]) begin
			@(posedge sys_clk);
			regulation_sel <= regs[i];
			repeat (2) @(posedge sys_clk);
			#1 chk({15'h0000, cc_enable}, {15'h0000, cc_exp[i]});
		end
		@(posedge sys_clk);
		current_range <= 16'h0064;
		repeat (2) @(posedge sys_clk);
		#1 chk({15'h0000, ka_mode}, 16'h0001);
		@(posedge sys_clk);
		current_range <= RANGE_PERCENT;
		regulation_sel <= REG_SENSOR_A;
		repeat (2) @(posedge sys_clk);
		#1 chk({15'h0000, ka_mode}, 16'h0000);
		weld(16'h0064, 1'b0, 1'b0);
		disp(DSP_CURRENT, 1'b0);
		chk(display_value, 16'h0064);
		op.press(0);
		disp(DSP_PHASE, 1'b0);
		chk(display_value, 16'h0037);
		op.press(1);
		chk(display_value, 16'h0064);
		op.press(2);
		disp(DSP_BLANK, 1'b0);
		weld(16'h0064, 1'b1, 1'b0);
		disp(DSP_TAP_UP, 1'b0);
		@(posedge sys_clk);
		phase_shift <= 8'h52;
		op.press(0);
		disp(DSP_PHASE, 1'b0);
		chk(display_value, 16'h0052);
		op.press(1);
		disp(DSP_CURRENT, 1'b0);
		weld(16'h0064, 1'b0, 1'b1);
		disp(DSP_TAP_DN, 1'b0);
		op.press(2);
		disp(DSP_BLANK, 1'b0);
		weld(16'h0005, 1'b0, 1'b0);
		disp(DSP_LO, 1'b1);
		chk({15'h0000, alarm_valve_output}, 16'h0000);
		weld(16'h012C, 1'b0, 1'b0);
		disp(DSP_HI, 1'b1);
		@(posedge sys_clk);
		hi_limit <= 16'h0000;
		weld(16'h006F, 1'b0, 1'b0);
		disp(DSP_HI, 1'b1);
		weld(16'h006D, 1'b0, 1'b0);
		disp(DSP_CURRENT, 1'b0);
		@(posedge sys_clk);
		hi_limit <= 16'h00C8;
		lo_limit <= 16'h0000;
		weld(16'h0059, 1'b0, 1'b0);
		disp(DSP_LO, 1'b1);
		@(posedge sys_clk);
		lo_limit <= 16'h000A;
		process_output_sel <= PO_ALARM;
		n = valve_lines;
		weld(16'h0005, 1'b0, 1'b0);
		disp(DSP_LO, 1'b1);
		chk({15'h0000, alarm_valve_output}, 16'h0001);
		m = 0;
		while (alarm_valve_output === 1'b1 && m < 400) begin
			@(posedge sys_clk);
			m++;
			#1;
		end
		n = valve_lines - n;
		chk(n[15:0], {10'h000, VALVE_LINE_CYCLES});
		@(posedge sys_clk);
		process_output_sel <= PO_STOP;
		weld(16'h0005, 1'b0, 1'b0);
		disp(DSP_LO, 1'b0);
		chk({15'h0000, abort_seen}, 16'h0001);
		chk({15'h0000, initiate_locked}, 16'h0001);
		op.initiate(started);
		chk({15'h0000, started}, 16'h0000);
		op.press(1);
		chk({15'h0000, initiate_locked}, 16'h0000);
		disp(DSP_BLANK, 1'b0);
		@(posedge sys_clk);
		process_output_sel <= 8'h00;
		weld(16'h0064, 1'b0, 1'b0);
		disp(DSP_BLANK, 1'b0);
		@(posedge sys_clk);
		percent_selected <= 1'b1;
		weld(16'h0050, 1'b0, 1'b0);
		disp(DSP_CURRENT, 1'b0);
		chk(display_value, 16'h0050);
		@(posedge sys_clk);
		measured_current <= 16'h0000;
		repeat (700) @(posedge sys_clk);
		#1 chk({8'h00, firing_percent}, {8'h00, FIRE_MAX_PCT});
		@(posedge sys_clk);
		measured_current <= 16'hFFFF;
		repeat (700) @(posedge sys_clk);
		#1 chk({8'h00, firing_percent}, {8'h00, FIRE_MIN_PCT});
		@(posedge sys_clk);
		regulation_sel <= REG_OFF;
		programmed_current <= 16'h0046;
		repeat (4) @(posedge sys_clk);
		#1 chk({8'h00, firing_percent}, 16'h0046);
		print_verdict();
	end
endmodule
